// ==== verilog/irseq_top.sv ====
// Readout sequencer for an infrared focal plane array
`timescale 1ns/10ps
module irseq_top
#(
  parameter int LINES = irseq_pkg::LINES_DEF,
  parameter int COLS  = irseq_pkg::COLS_DEF
)
(
  input  wire logic                                mclk,
  input  wire logic                                reset_n,
  input  wire logic                                start,
  input  wire logic [2:0]                          mode_sel,
  input  wire logic [1:0]                          out_sel,
  input  wire logic [irseq_pkg::NREAD_W-1:0]       read_count,
  input  wire logic [irseq_pkg::CNT_W-1:0]         integ_time,
  input  wire logic [9:0]                          sel_line,
  input  wire logic [9:0]                          sel_col,
  input  wire logic [irseq_pkg::PIX_W-1:0]         video_in,
  output logic                                     line_reset,
  output logic                                     row_clk,
  output logic                                     col_clk,
  output logic [9:0]                               row_addr,
  output logic [9:0]                               col_addr,
  output logic [irseq_pkg::ACC_W-1:0]              pix_out,
  output logic                                     pix_valid,
  output logic [irseq_pkg::CHAN_W-1:0]             pix_chan,
  output logic                                     frame_valid,
  output logic [2:0]                               frame_mode,
  output logic                                     busy
);
  localparam int NPIX = LINES * COLS;
  localparam int AW   = $clog2(NPIX);

  typedef struct packed
  {
    irseq_pkg::irseq_state_t       st;
    logic [2:0]                    mode;
    logic [1:0]                    outm;
    logic [irseq_pkg::NREAD_W-1:0] nread;
    logic [irseq_pkg::CNT_W-1:0]   itime;
    logic [irseq_pkg::CNT_W-1:0]   icnt;
    logic [irseq_pkg::NREAD_W-1:0] pass;
    logic [9:0]                    row;
    logic [9:0]                    col;
    logic                          rst_o;
    logic                          rclk;
    logic                          cclk;
    logic [irseq_pkg::ACC_W-1:0]   pout;
    logic                          pval;
    logic [irseq_pkg::CHAN_W-1:0]  chan;
    logic                          fval;
    logic [2:0]                    fmode;
    logic                          prime;
    logic                          sync1;
    logic                          sync2;
    logic                          bsy;
    logic [irseq_pkg::PIX_W-1:0]   vid1;
    logic [irseq_pkg::PIX_W-1:0]   vid2;
  } irseq_state_s_t;

  irseq_state_s_t s_q;
  irseq_state_s_t s_d;
  logic           tick;

  // Reference frame store; large, but flip-flops keep it portable
  logic [irseq_pkg::ACC_W-1:0] ref_mem [NPIX];
  logic                        ref_we;
  logic [AW-1:0]               ref_idx;
  logic [irseq_pkg::ACC_W-1:0] ref_wd;

  irseq_pixdiv #(.DIV(irseq_pkg::PIXDIV)) u_div
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  function automatic logic [irseq_pkg::CHAN_W-1:0] chan_of(input logic [9:0] c,
                                                           input logic [1:0] om);
    logic [irseq_pkg::CHAN_W-1:0] blk;
    blk = irseq_pkg::CHAN_W'(c / irseq_pkg::BLOCK_COLS);
    if (om == irseq_pkg::IRSEQ_OUT_SINGLE)
      chan_of = '0;
    else if (om == irseq_pkg::IRSEQ_OUT_SHUF)
      chan_of = blk + 1'b1;
    else
      chan_of = blk;
  endfunction

  logic last_col;
  logic last_row;
  logic pix_sel;
  logic [irseq_pkg::ACC_W-1:0] vid_ext;
  logic [irseq_pkg::ACC_W-1:0] ref_rd;

  assign last_col = (s_q.col == 10'(COLS - 1));
  assign last_row = (s_q.row == 10'(LINES - 1));
  assign ref_idx  = AW'(s_q.row * COLS + s_q.col);
  assign ref_rd   = ref_mem[ref_idx];
  assign vid_ext  = irseq_pkg::ACC_W'(s_q.vid2);
  // Single pixel mode samples the chosen pixel within each column block
  assign pix_sel  = (s_q.row == sel_line) &&
                    ((s_q.col % irseq_pkg::BLOCK_COLS) == (sel_col % irseq_pkg::BLOCK_COLS));

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = start;
    s_d.sync2 = s_q.sync1;
    s_d.vid1 = video_in;
    s_d.vid2 = s_q.vid1;
    s_d.pval = 1'b0;
    s_d.fval = 1'b0;
    s_d.rst_o = 1'b0;
    s_d.rclk = 1'b0;
    s_d.cclk = 1'b0;
    ref_we = 1'b0;
    ref_wd = '0;
    unique case (s_q.st)
      irseq_pkg::IRSEQ_IDLE:
      begin
        if (s_q.prime)
        begin
          s_d.mode = mode_sel;
          s_d.outm = out_sel;
          s_d.nread = (read_count == '0) ? irseq_pkg::NREAD_W'(1) : read_count;
          s_d.itime = integ_time;
          s_d.row = '0;
          s_d.col = '0;
          s_d.pass = '0;
          s_d.st = (mode_sel == irseq_pkg::IRSEQ_MODE_FAST ||
                    mode_sel == irseq_pkg::IRSEQ_MODE_LINE) ?
                   irseq_pkg::IRSEQ_LRST : irseq_pkg::IRSEQ_RESET;
        end
      end
      irseq_pkg::IRSEQ_RESET:
      begin
        // One pulse per line while the column register is walked
        if (tick)
        begin
          s_d.cclk = 1'b1;
          if (s_q.col == '0)
            s_d.rst_o = 1'b1;
          if (last_col)
          begin
            s_d.col = '0;
            s_d.rclk = 1'b1;
            s_d.row = s_q.row + 1'b1;
            if (last_row)
            begin
              s_d.row = '0;
              s_d.st = irseq_pkg::IRSEQ_READ0;
            end
          end
          else
            s_d.col = s_q.col + 1'b1;
        end
      end
      irseq_pkg::IRSEQ_LRST:
      begin
        // Fast reset: line reset, then its reset level read in the same pass
        if (tick)
        begin
          s_d.rst_o = 1'b1;
          s_d.col = '0;
          s_d.st = irseq_pkg::IRSEQ_LREF;
        end
      end
      irseq_pkg::IRSEQ_LREF:
      begin
        if (tick)
        begin
          s_d.cclk = 1'b1;
          ref_we = 1'b1;
          ref_wd = vid_ext;
          if (last_col)
          begin
            s_d.col = '0;
            s_d.rclk = 1'b1;
            s_d.row = s_q.row + 1'b1;
            if (last_row)
            begin
              s_d.row = '0;
              s_d.icnt = '0;
              s_d.st = irseq_pkg::IRSEQ_INTEG;
            end
            else if (s_q.mode == irseq_pkg::IRSEQ_MODE_LINE && s_q.pass != '0)
              s_d.st = irseq_pkg::IRSEQ_READ1;
            else
              s_d.st = irseq_pkg::IRSEQ_LRST;
          end
          else
            s_d.col = s_q.col + 1'b1;
        end
      end
      irseq_pkg::IRSEQ_READ0:
      begin
        if (tick)
        begin
          s_d.cclk = 1'b1;
          ref_we = 1'b1;
          // Accumulate post-reset reads; averaged by division at output
          ref_wd = (s_q.pass == '0) ? vid_ext : ref_rd + vid_ext;
          if (last_col)
          begin
            s_d.col = '0;
            s_d.rclk = 1'b1;
            s_d.row = s_q.row + 1'b1;
            if (last_row)
            begin
              s_d.row = '0;
              if (s_q.mode == irseq_pkg::IRSEQ_MODE_MEP &&
                  s_q.pass + 1'b1 < s_q.nread)
                s_d.pass = s_q.pass + 1'b1;
              else
              begin
                s_d.pass = '0;
                s_d.icnt = '0;
                s_d.st = irseq_pkg::IRSEQ_INTEG;
              end
            end
          end
          else
            s_d.col = s_q.col + 1'b1;
        end
      end
      irseq_pkg::IRSEQ_INTEG:
      begin
        if (tick)
        begin
          s_d.icnt = s_q.icnt + 1'b1;
          if (s_q.icnt >= s_q.itime)
          begin
            s_d.st = irseq_pkg::IRSEQ_READ1;
            s_d.pass = (s_q.mode == irseq_pkg::IRSEQ_MODE_LINE) ?
                       irseq_pkg::NREAD_W'(1) : '0;
          end
        end
      end
      irseq_pkg::IRSEQ_READ1:
      begin
        if (tick)
        begin
          s_d.cclk = 1'b1;
          if (s_q.mode == irseq_pkg::IRSEQ_MODE_MEP)
          begin
            ref_we = 1'b1;
            // Running sum kept as reset_sum - integrated_sum, negated at end
            ref_wd = ref_rd - vid_ext;
            if (s_q.pass + 1'b1 == s_q.nread)
            begin
              s_d.pout = (vid_ext - ref_rd) / irseq_pkg::ACC_W'(s_q.nread);
              s_d.pval = 1'b1;
            end
          end
          else if (s_q.mode == irseq_pkg::IRSEQ_MODE_SINGLE)
          begin
            // Raw sample: no reset-level frame exists in this mode
            if (pix_sel)
            begin
              s_d.pout = vid_ext;
              s_d.pval = 1'b1;
            end
          end
          else
          begin
            s_d.pout = vid_ext - ref_rd;
            s_d.pval = 1'b1;
          end
          s_d.chan = chan_of(s_q.col, s_q.outm);
          if (last_col)
          begin
            s_d.col = '0;
            if (s_q.mode == irseq_pkg::IRSEQ_MODE_LINE)
            begin
              // Row holds: this same line is reset and its level read next
              s_d.st = irseq_pkg::IRSEQ_LRST;
              if (last_row)
              begin
                s_d.fval = 1'b1;
                s_d.fmode = s_q.mode;
              end
            end
            else
            begin
              s_d.rclk = 1'b1;
              s_d.row = s_q.row + 1'b1;
              if (last_row)
              begin
                s_d.row = '0;
                if (s_q.mode == irseq_pkg::IRSEQ_MODE_MEP &&
                    s_q.pass + 1'b1 < s_q.nread)
                  s_d.pass = s_q.pass + 1'b1;
                else
                begin
                  s_d.fval = 1'b1;
                  s_d.fmode = s_q.mode;
                  s_d.st = irseq_pkg::IRSEQ_IDLE;
                end
              end
            end
          end
          else
            s_d.col = s_q.col + 1'b1;
        end
      end
      default:
      begin
        s_d.st = irseq_pkg::IRSEQ_IDLE;
      end
    endcase
    // Single pixel mode skips the post-reset read
    if (s_q.st == irseq_pkg::IRSEQ_RESET && s_d.st == irseq_pkg::IRSEQ_READ0 &&
        s_q.mode == irseq_pkg::IRSEQ_MODE_SINGLE)
    begin
      s_d.st = irseq_pkg::IRSEQ_INTEG;
      s_d.icnt = '0;
    end
    s_d.bsy = (s_d.st != irseq_pkg::IRSEQ_IDLE);
    // Only the second synchroniser stage feeds logic
    s_d.prime = s_q.sync2 & (s_q.st == irseq_pkg::IRSEQ_IDLE) & ~s_q.prime;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.st <= irseq_pkg::IRSEQ_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ref_we)
      ref_mem[ref_idx] <= ref_wd;
  end

  assign line_reset  = s_q.rst_o;
  assign row_clk     = s_q.rclk;
  assign col_clk     = s_q.cclk;
  assign row_addr    = s_q.row;
  assign col_addr    = s_q.col;
  assign pix_out     = s_q.pout;
  assign pix_valid   = s_q.pval;
  assign pix_chan    = s_q.chan;
  assign frame_valid = s_q.fval;
  assign frame_mode  = s_q.fmode;
  assign busy        = s_q.bsy;

  a_reset_to_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.st == irseq_pkg::IRSEQ_READ0) |->
    ($past(s_q.st) == irseq_pkg::IRSEQ_RESET || $past(s_q.st) == irseq_pkg::IRSEQ_READ0))
    else $error("read after reset came from wrong state");
  a_cds_diff: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.st == irseq_pkg::IRSEQ_READ1 && tick && s_q.mode == irseq_pkg::IRSEQ_MODE_CDS)
    |=> pix_valid && pix_out == $past(vid_ext) - $past(ref_rd))
    else $error("double-sample output not difference");
  a_fast_diff: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.st == irseq_pkg::IRSEQ_READ1 && tick && s_q.mode == irseq_pkg::IRSEQ_MODE_FAST)
    |=> pix_valid && pix_out == $past(vid_ext) - $past(ref_rd))
    else $error("fast reset output not difference");
  a_fast_noread0: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.mode == irseq_pkg::IRSEQ_MODE_FAST && busy) |-> s_q.st != irseq_pkg::IRSEQ_READ0)
    else $error("fast reset used a third pass");
  a_line_order: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.st == irseq_pkg::IRSEQ_LRST && tick) |=> line_reset && s_q.st == irseq_pkg::IRSEQ_LREF)
    else $error("line reset not followed by level read");
  a_fast_done: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.mode == irseq_pkg::IRSEQ_MODE_FAST && s_q.st == irseq_pkg::IRSEQ_READ1)
    |=> s_q.st != irseq_pkg::IRSEQ_LRST)
    else $error("fast reset began before frame read");
  a_reset_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.st == irseq_pkg::IRSEQ_RESET && tick && s_q.col == '0) |=> line_reset)
    else $error("missing line reset pulse");
  a_frame_tag: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_valid |-> frame_mode == s_q.mode)
    else $error("frame tag mismatch");
  a_nread_min: assert property (@(posedge mclk) disable iff (!reset_n)
    busy |-> s_q.nread != '0)
    else $error("read count zero");
endmodule

// ==== include/irseq_pkg.sv ====
// Shared constants and types for the infrared array readout sequencer
package irseq_pkg;
  localparam int LINES_DEF    = 1024;
  localparam int COLS_DEF     = 1024;
  localparam int PIX_W        = 16;
  localparam int ACC_W        = 24;
  localparam int BLOCK_COLS   = 128;
  localparam int NCHAN        = 8;
  localparam int CHAN_W       = 3;
  localparam int CNT_W        = 24;
  localparam int NREAD_W      = 4;
  localparam int PIXCLK_NS    = 3125;
  localparam int CLK_NS       = 10;
  localparam int PIXDIV       = (PIXCLK_NS + CLK_NS * 100 - 1) / (CLK_NS * 100);
  localparam int DIV_W        = 4;

  typedef enum logic [2:0]
  {
    IRSEQ_MODE_CDS      = 3'h0,
    IRSEQ_MODE_FAST     = 3'h1,
    IRSEQ_MODE_LINE     = 3'h2,
    IRSEQ_MODE_MEP      = 3'h3,
    IRSEQ_MODE_SINGLE   = 3'h4
  } irseq_mode_t;

  typedef enum logic [1:0]
  {
    IRSEQ_OUT_SINGLE    = 2'h0,
    IRSEQ_OUT_UNSHUF    = 2'h1,
    IRSEQ_OUT_SHUF      = 2'h2
  } irseq_out_t;

  typedef enum logic [6:0]
  {
    IRSEQ_IDLE   = 7'h01,
    IRSEQ_RESET  = 7'h02,
    IRSEQ_READ0  = 7'h04,
    IRSEQ_INTEG  = 7'h08,
    IRSEQ_READ1  = 7'h10,
    IRSEQ_LRST   = 7'h20,
    IRSEQ_LREF   = 7'h40
  } irseq_state_t;
endpackage

// ==== verilog/irseq_pixdiv.sv ====
// Pixel clock enable divider for the readout sequencer
`timescale 1ns/10ps
module irseq_pixdiv
#(
  parameter int DIV = 4
)
(
  input  wire logic mclk,
  input  wire logic reset_n,
  output logic      tick
);
  typedef struct packed
  {
    logic [irseq_pkg::DIV_W-1:0] cnt;
    logic                        tick;
  } irseq_div_t;

  irseq_div_t s_q;
  irseq_div_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == irseq_pkg::DIV_W'(DIV - 1))
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ==== test/irseq_det_model.sv ====
// Behavioural detector array model driving video from the sequencer's clocking
`timescale 1ns/10ps
module irseq_det_model
#(
  parameter int LINES = 4,
  parameter int COLS  = 4,
  parameter int T_EXP = 400
)
(
  input  wire logic                         mclk,
  input  wire logic                         line_reset,
  input  wire logic [9:0]                   row_addr,
  input  wire logic [9:0]                   col_addr,
  output logic      [irseq_pkg::PIX_W-1:0]  video_in,
  output int                                n_lrst
);
  int unsigned now;
  int unsigned rst_at [LINES];

  initial
  begin
    now      = 0;
    n_lrst   = 0;
    video_in = 16'h0000;
    foreach (rst_at[i])
      rst_at[i] = 0;
  end

  // Signal appears only once a line has integrated long enough since its reset
  always @(posedge mclk)
  begin
    int r;
    int c;
    r = row_addr % LINES;
    c = col_addr % COLS;
    now <= now + 1;
    if (line_reset === 1'b1)
    begin
      rst_at[r] <= now;
      n_lrst    <= n_lrst + 1;
    end
    // A line reset in this very cycle shows its reset level only
    video_in <= 16'h0100 + 16'(r * 16 + c)
                + ((line_reset !== 1'b1 && now - rst_at[r] >= T_EXP) ?
                   16'(r * COLS + c + 1) : 16'h0000);
  end
endmodule

// ==== test/ir_array_readout_sequencer_bench.sv ====
// Self-checking bench for the readout sequencer against the detector model
`timescale 1ns/10ps
module ir_array_readout_sequencer_bench;
  logic                             mclk;
  logic                             reset_n;
  logic                             start;
  logic [2:0]                       mode_sel;
  logic [1:0]                       out_sel;
  logic [irseq_pkg::NREAD_W-1:0]    read_count;
  logic [irseq_pkg::CNT_W-1:0]      integ_time;
  logic [9:0]                       sel_line;
  logic [9:0]                       sel_col;
  logic [irseq_pkg::PIX_W-1:0]      video_in;
  logic                             line_reset;
  logic                             row_clk;
  logic                             col_clk;
  logic [9:0]                       row_addr;
  logic [9:0]                       col_addr;
  logic [irseq_pkg::ACC_W-1:0]      pix_out;
  logic                             pix_valid;
  logic [irseq_pkg::CHAN_W-1:0]     pix_chan;
  logic                             frame_valid;
  logic [2:0]                       frame_mode;
  logic                             busy;
  int                               n_lrst;
  int                               n_mismatch;
  int                               checks;
  int                               cnt;
  int                               l0;
  logic [31:0]                      sum;
  logic                             chan_bad;
  logic [2:0]                       mode_got;

  irseq_top #(.LINES(4), .COLS(4)) i_dut
  (
    .mclk(mclk), .reset_n(reset_n), .start(start), .mode_sel(mode_sel),
    .out_sel(out_sel), .read_count(read_count), .integ_time(integ_time),
    .sel_line(sel_line), .sel_col(sel_col), .video_in(video_in),
    .line_reset(line_reset), .row_clk(row_clk), .col_clk(col_clk),
    .row_addr(row_addr), .col_addr(col_addr), .pix_out(pix_out),
    .pix_valid(pix_valid), .pix_chan(pix_chan), .frame_valid(frame_valid),
    .frame_mode(frame_mode), .busy(busy)
  );

  irseq_det_model #(.LINES(4), .COLS(4), .T_EXP(400)) i_det
  (
    .mclk(mclk), .line_reset(line_reset), .row_addr(row_addr),
    .col_addr(col_addr), .video_in(video_in), .n_lrst(n_lrst)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task end_sim;
    $display("Counts: checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task kick(input logic [2:0] m, input logic [1:0] o, input logic [3:0] n);
    @(posedge mclk);
    mode_sel   <= m;
    out_sel    <= o;
    read_count <= n;
    start      <= 1'b1;
    repeat (3) @(posedge mclk);
    start      <= 1'b0;
  endtask

  // Sums a frame; pixel order is left to the design, so only totals and each pixel's channel are judged
  task frame(input logic [2:0] exp_chan);
    int  i;
    logic seen;
    sum = 0;
    cnt = 0;
    chan_bad = 1'b0;
    seen = 1'b0;
    for (i = 0; i < 40000 && !seen; i++)
    begin
      @(negedge mclk);
      if (pix_valid === 1'b1)
      begin
        sum = sum + 32'(pix_out);
        cnt++;
        if (pix_chan !== exp_chan)
          chan_bad = 1'b1;
      end
      if (frame_valid === 1'b1)
      begin
        seen = 1'b1;
        mode_got = frame_mode;
      end
    end
    if (!seen)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task idle_wait;
    int i;
    for (i = 0; i < 2000 && busy !== 1'b0; i++)
      @(negedge mclk);
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task t_cds;
    l0 = n_lrst;
    kick(3'h0, 2'h1, 4'h1);
    frame(3'h0);
    idle_wait();
    cmp_val(sum, 32'h88);
    cmp_val(cnt, 16);
    cmp_val(chan_bad, 0);
    cmp_val(mode_got, 3'h0);
    cmp_val(n_lrst - l0, 4);
  endtask

  task t_shuf;
    kick(3'h0, 2'h2, 4'h1);
    frame(3'h1);
    idle_wait();
    cmp_val(chan_bad, 0);
    cmp_val(sum, 32'h88);
  endtask

  task t_fast;
    l0 = n_lrst;
    kick(3'h1, 2'h0, 4'h1);
    frame(3'h0);
    idle_wait();
    cmp_val(sum, 32'h88);
    cmp_val(cnt, 16);
    cmp_val(mode_got, 3'h1);
    cmp_val(n_lrst - l0, 4);
  endtask

  // Read count changes after start; a late count would spoil the averages
  task t_mep;
    kick(3'h3, 2'h1, 4'h2);
    @(posedge mclk);
    read_count <= 4'hf;
    frame(3'h0);
    idle_wait();
    cmp_val(sum, 32'h88);
    cmp_val(mode_got, 3'h3);
  endtask

  task t_mep0;
    kick(3'h3, 2'h1, 4'h0);
    frame(3'h0);
    idle_wait();
    cmp_val(sum, 32'h88);
    cmp_val(cnt, 16);
  endtask

  task t_single;
    l0 = n_lrst;
    kick(3'h4, 2'h0, 4'h1);
    frame(3'h0);
    idle_wait();
    cmp_val(cnt, 1);
    cmp_val(sum, 32'h117);
    cmp_val(mode_got, 3'h4);
    cmp_val(n_lrst - l0, 4);
  endtask

  // First interlaced frame also spans the initial reset walk of every line, so only the second is judged
  task t_line;
    kick(3'h2, 2'h1, 4'h1);
    frame(3'h0);
    l0 = n_lrst;
    frame(3'h0);
    cmp_val(sum, 32'h88);
    cmp_val(cnt, 16);
    cmp_val(mode_got, 3'h2);
    cmp_val(n_lrst - l0, 4);
  endtask

  initial
  begin
    n_mismatch = 0;
    checks     = 0;
    reset_n    = 1'b0;
    start      = 1'b0;
    mode_sel   = 3'h0;
    out_sel    = 2'h0;
    read_count = 4'h1;
    integ_time = 24'h0000c8;
    sel_line   = 10'h001;
    sel_col    = 10'h001;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_cds();
    t_shuf();
    t_fast();
    t_mep();
    t_mep0();
    t_single();
    t_line();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    // Line mode never stops; a mid-run reset must leave it restartable
    t_cds();
    end_sim();
  end
endmodule
